// File: can_bus_fault_diagnostics_tb.sv
`timescale 1ns/1ps
module can_bus_fault_diagnostics_tb;
    localparam int TMO = 20;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic rx_diff = 1'b1;
    logic rec_short = 1'b0;
    logic dom_l = 1'b0;
    logic dom_h = 1'b0;
    logic therm = 1'b0;
    logic oc_h = 1'b0;
    logic oc_l = 1'b0;
    logic stuck = 1'b0;
    int fails = 0;
    int n_checks = 0;
    logic txd_pin, spi_valid, driver_enable, rxd_out, rxd_oe_n, rxd_pd;
    logic [7:0] spi_byte;
    logic [3:0] spi_rdata;
    cbfd_pkg::cbfd_status_t status;
    // pin level: short wins, else driver, else low with pull-down on, high with it off
    wire rxd_pin = stuck ? 1'b1 : (rxd_oe_n ? !rxd_pd : rxd_out);
    always #25 clock = ~clock;
    cbfd_host_model host (.clock(clock), .txd_pin(txd_pin),
        .spi_valid(spi_valid), .spi_byte(spi_byte));
    cbfd_diag #(.TXD_TIMEOUT(TMO)) dut_u (.clock(clock), .rst_n(rst_n),
        .txd_pin(txd_pin), .rxd_pin_sense(rxd_pin), .rx_diff(rx_diff),
        .recessive_short(rec_short), .dominant_canl_fault(dom_l),
        .dominant_canh_fault(dom_h), .thermal_event(therm),
        .overcurrent_canh(oc_h), .overcurrent_canl(oc_l),
        .spi_valid(spi_valid), .spi_byte(spi_byte), .spi_rdata(spi_rdata),
        .driver_enable(driver_enable), .rxd_out(rxd_out),
        .rxd_oe_n(rxd_oe_n), .rxd_pulldown_en(rxd_pd), .status(status));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // dominant then recessive phase on the receiver
    task automatic bus_cycles(input int n);
        repeat (n) begin
            rx_diff = 1'b0;
            cyc(6);
            rx_diff = 1'b1;
            cyc(6);
        end
    endtask
    task automatic t_classify();
        for (int k = 0; k < 2; k++) begin
            rec_short = 1'b1;
            cyc(8);
            chk({2'h0, status.bus_fault, status.bus_fault_unidentified},
                4'h3);
            host.xfer(cbfd_pkg::ADDR_CAN, 1'b0, 4'h0);
            chk(spi_rdata, 4'h6);
            dom_l = (k == 0);
            dom_h = (k == 1);
            bus_cycles(4);
            chk({3'h0, status.bus_fault_unidentified}, 4'h1);
            bus_cycles(2);
            chk({status.bus_fault, status.bus_fault_unidentified,
                status.canl_fault, status.canh_fault},
                {2'h2, k == 0, k == 1});
            host.xfer(k ? cbfd_pkg::ADDR_LPC : cbfd_pkg::ADDR_LINE_LOW,
                1'b0, 4'h0);
            chk({3'h0, spi_rdata[0]}, 4'h1);
            rec_short = 1'b0;
            dom_l = 1'b0;
            dom_h = 1'b0;
            bus_cycles(1);
        end
    endtask
    task automatic t_rxd();
        stuck = 1'b1;
        bus_cycles(2);
        chk({3'h0, status.rx_stuck_recessive_flag}, 4'h0);
        bus_cycles(1);
        chk({driver_enable, rxd_oe_n, rxd_pd,
            status.rx_stuck_recessive_flag}, 4'h7);
        host.reenable();
        cyc(4);
        chk({3'h0, driver_enable}, 4'h0);
        stuck = 1'b0;
        cyc(4);
        host.reenable();
        cyc(4);
        chk({driver_enable, rxd_oe_n, rxd_pd, rxd_out}, 4'h9);
        host.xfer(cbfd_pkg::ADDR_LPC, 1'b0, 4'h0);
        chk(spi_rdata, 4'h2);
        host.xfer(cbfd_pkg::ADDR_LPC, 1'b0, 4'h0);
        chk(spi_rdata, 4'h0);
    endtask
    task automatic t_txd();
        host.hold_txd(1'b0);
        cyc(TMO + 8);
        chk({2'h0, driver_enable, status.txd_dominant_fault}, 4'h1);
        host.xfer(cbfd_pkg::ADDR_LINE_LOW, 1'b0, 4'h0);
        chk(spi_rdata, 4'h2);
        host.reenable();
        cyc(4);
        chk({3'h0, driver_enable}, 4'h0);
        host.hold_txd(1'b1);
        cyc(30);
        chk({3'h0, driver_enable}, 4'h0);
        host.reenable();
        cyc(4);
        chk({3'h0, driver_enable}, 4'h1);
    endtask
    task automatic t_therm();
        for (int k = 0; k < 3; k++) begin
            {therm, oc_h, oc_l} = 3'h4 >> k;
            cyc(6);
            {therm, oc_h, oc_l} = 3'h0;
            cyc(4);
            host.xfer(cbfd_pkg::ADDR_CAN, 1'b0, 4'h0);
            chk({3'h0, spi_rdata[cbfd_pkg::CAN_BIT_THERM]}, 4'h1);
            cyc(2);
            host.xfer(cbfd_pkg::ADDR_CAN, 1'b0, 4'h0);
            chk({3'h0, spi_rdata[cbfd_pkg::CAN_BIT_THERM]}, 4'h0);
        end
        host.xfer(3'h7, 1'b0, 4'h0);
        chk(spi_rdata, 4'h0);
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        cyc(20);
        rst_n = 1'b1;
        cyc(4);
        t_classify();
        t_rxd();
        t_txd();
        t_therm();
        test_done();
    end
    // hang guard, several times the expected run
    initial begin
        #(4000 * 50);
        fails++;
        test_done();
    end
endmodule

// File: cbfd_diag.sv
`timescale 1ns/1ps
// Function
// - recessive short detected but line unknown
// - canl fault to line reg, canh to lpc
// - d2 any fault, d1 while unidentified
// - classified fault recorded, d1 cleared
// - one cycle starts, five cycles identify
// - d1 holds until five same cycles, or until the fault is gone with the bus recessive
// - fault flag raised even on idle bus
// - sample rxd at receiver rising edge
// - three high samples mean rxd stuck
// - stuck: latch flag, disable driver, report
// - stuck: release rxd, weak pull-down on
// - rxd fault: re-enable needs clear plus cmd
// - txd dominant timeout disables driver, flags
// - timeout: re-enable needs txd high plus cmd
// - txd-rxd short same timeout, no autorecovery
// - thermal or over-current sets flag
// - spi byte: addr3, rw, data4
module cbfd_diag #(
    parameter int TXD_TIMEOUT = cbfd_pkg::TXD_TIMEOUT_DEFAULT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic txd_pin,
    input wire logic rxd_pin_sense,
    input wire logic rx_diff,
    input wire logic recessive_short,
    input wire logic dominant_canl_fault,
    input wire logic dominant_canh_fault,
    input wire logic thermal_event,
    input wire logic overcurrent_canh,
    input wire logic overcurrent_canl,
    input wire logic spi_valid,
    input wire logic [7:0] spi_byte,
    output logic [3:0] spi_rdata,
    output logic driver_enable,
    output logic rxd_out,
    output logic rxd_oe_n,
    output logic rxd_pulldown_en,
    output cbfd_pkg::cbfd_status_t status
);
    localparam logic [cbfd_pkg::TXD_CNT_W-1:0] TMO =
        TXD_TIMEOUT[cbfd_pkg::TXD_CNT_W-1:0];

    // pin inputs brought into the clock domain
    // idle-high pins pass inverted, so the flops reset to their idle
    // level and no false edge or dominant count follows reset
    logic [8:0] pins_s;
    cbfd_sync #(.W(9)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .d({~txd_pin, ~rxd_pin_sense, ~rx_diff, recessive_short,
            dominant_canl_fault, dominant_canh_fault, thermal_event,
            overcurrent_canh, overcurrent_canl}),
        .q(pins_s)
    );
    wire txd_s = ~pins_s[8];
    wire rxd_s = ~pins_s[7];
    wire rxdiff_s = ~pins_s[6];
    wire rec_short_s = pins_s[5];
    cbfd_pkg::cbfd_line_t dom_sig;
    assign dom_sig = '{canl_fault: pins_s[4], canh_fault: pins_s[3]};
    wire therm_s = pins_s[2];
    wire oc_s = pins_s[1] | pins_s[0];

    // spi byte decode
    wire [2:0] spi_addr =
        spi_byte[cbfd_pkg::SPI_ADDR_MSB:cbfd_pkg::SPI_ADDR_LSB];
    wire spi_write = spi_valid & spi_byte[cbfd_pkg::SPI_RW_BIT];
    wire spi_read = spi_valid & ~spi_byte[cbfd_pkg::SPI_RW_BIT];
    wire [3:0] spi_wdata =
        spi_byte[cbfd_pkg::SPI_DATA_MSB:cbfd_pkg::SPI_DATA_LSB];
    wire reenable_cmd = spi_write && spi_addr == cbfd_pkg::ADDR_CAN &&
        spi_wdata[cbfd_pkg::CAN_BIT_CLR];

    // recessive-dominant cycle tracking
    logic rxdiff_d_reg;
    logic seen_rec_reg, seen_rec_next;
    wire rec_to_dom = rxdiff_d_reg & ~rxdiff_s;
    wire dom_to_rec = ~rxdiff_d_reg & rxdiff_s; // receiver low-to-high
    wire rd_cycle = rec_to_dom & seen_rec_reg;

    // line fault classifier
    typedef enum logic [1:0] {CL_IDLE, CL_ACQ, CL_DONE} cbfd_cl_t;
    cbfd_cl_t cl_reg, cl_next;
    logic [2:0] same_cnt_reg, same_cnt_next;
    cbfd_pkg::cbfd_line_t cand_reg, cand_next;
    cbfd_pkg::cbfd_line_t line_reg, line_next;
    wire dom_any = dom_sig.canl_fault | dom_sig.canh_fault;
    wire fault_seen = rec_short_s | dom_any;
    wire same_sig = dom_sig == cand_reg;

    // classifier next state
    always_comb begin
        cl_next = cl_reg;
        same_cnt_next = same_cnt_reg;
        cand_next = cand_reg;
        line_next = line_reg;
        seen_rec_next = seen_rec_reg | rxdiff_s;
        if (rec_to_dom) begin
            seen_rec_next = 1'b0;
        end
        case (cl_reg)
            CL_IDLE: begin
                if (fault_seen) begin
                    cl_next = CL_ACQ;
                    same_cnt_next = 3'h0;
                    cand_next = '0;
                end
            end
            CL_ACQ: begin
                if (rd_cycle) begin
                    if (dom_any && same_sig) begin
                        same_cnt_next = same_cnt_reg + 3'h1;
                    end else begin
                        cand_next = dom_sig;
                        same_cnt_next = dom_any ? 3'h1 : 3'h0;
                    end
                    if (dom_any && same_sig &&
                        same_cnt_reg + 3'h1 >= cbfd_pkg::IDENT_CYCLES) begin
                        cl_next = CL_DONE;
                        line_next = dom_sig;
                    end
                end else if (!fault_seen && rxdiff_s) begin
                    cl_next = CL_IDLE;
                end
            end
            CL_DONE: begin
                if (rd_cycle && !dom_any && !rec_short_s) begin
                    cl_next = CL_IDLE;
                    line_next = '0;
                end
            end
            default: begin
                cl_next = CL_IDLE;
            end
        endcase
    end

    // classifier registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cl_reg <= CL_IDLE;
            same_cnt_reg <= 3'h0;
            cand_reg <= '0;
            line_reg <= '0;
            rxdiff_d_reg <= 1'b1;
            seen_rec_reg <= 1'b0;
        end else begin
            cl_reg <= cl_next;
            same_cnt_reg <= same_cnt_next;
            cand_reg <= cand_next;
            line_reg <= line_next;
            rxdiff_d_reg <= rxdiff_s;
            seen_rec_reg <= seen_rec_next;
        end
    end

    // rxd stuck recessive detector
    logic [1:0] stuck_cnt_reg, stuck_cnt_next;
    logic rx_stuck_reg, rx_stuck_next;
    logic rxd_fault_reg, rxd_fault_next;
    always_comb begin
        stuck_cnt_next = stuck_cnt_reg;
        rx_stuck_next = rx_stuck_reg;
        rxd_fault_next = rxd_fault_reg;
        if (dom_to_rec && !rxd_fault_reg) begin
            if (rxd_s) begin
                stuck_cnt_next = stuck_cnt_reg + 2'h1;
                if (stuck_cnt_reg + 2'h1 >= cbfd_pkg::STUCK_SAMPLES) begin
                    rxd_fault_next = 1'b1;
                    rx_stuck_next = 1'b1;
                    stuck_cnt_next = 2'h0;
                end
            end else begin
                stuck_cnt_next = 2'h0;
            end
        end
        // released pin pulled low shows the fault has gone
        if (rxd_fault_reg && !rxd_s && reenable_cmd) begin
            rxd_fault_next = 1'b0;
        end
        // a detection in the same cycle as the read keeps the flag set
        if (spi_read && spi_addr == cbfd_pkg::ADDR_LPC &&
            !rxd_fault_next) begin
            rx_stuck_next = 1'b0;
        end
    end

    // dominant timeout detector
    logic [cbfd_pkg::TXD_CNT_W-1:0] dom_cnt_reg, dom_cnt_next;
    logic txd_fault_reg, txd_fault_next;
    always_comb begin
        dom_cnt_next = dom_cnt_reg;
        txd_fault_next = txd_fault_reg;
        if (txd_s) begin
            dom_cnt_next = '0;
        end else if (dom_cnt_reg < TMO) begin
            dom_cnt_next = dom_cnt_reg + 1'b1;
        end
        if (!txd_s && dom_cnt_reg >= TMO) begin
            txd_fault_next = 1'b1;
        end else if (txd_fault_reg && txd_s && reenable_cmd) begin
            txd_fault_next = 1'b0;
        end
    end

    // thermal flag, cleared by reading the can register when gone
    logic therm_reg, therm_next;
    always_comb begin
        therm_next = therm_reg;
        if (spi_read && spi_addr == cbfd_pkg::ADDR_CAN) begin
            therm_next = 1'b0;
        end
        if (therm_s || oc_s) begin
            therm_next = 1'b1;
        end
    end

    // status and read data assembly
    cbfd_pkg::cbfd_status_t st_next;
    assign st_next = '{
        bus_fault: cl_reg != CL_IDLE,
        bus_fault_unidentified: cl_reg == CL_ACQ,
        thermal_overcurrent_flag: therm_reg,
        canl_fault: line_reg.canl_fault,
        txd_dominant_fault: txd_fault_reg,
        canh_fault: line_reg.canh_fault,
        rx_stuck_recessive_flag: rx_stuck_reg
    };
    logic [3:0] rdata_next;
    always_comb begin
        rdata_next = 4'h0;
        case (spi_addr)
            cbfd_pkg::ADDR_CAN: begin
                rdata_next[cbfd_pkg::CAN_BIT_F] = st_next.bus_fault;
                rdata_next[cbfd_pkg::CAN_BIT_UF] =
                    st_next.bus_fault_unidentified;
                rdata_next[cbfd_pkg::CAN_BIT_THERM] = therm_reg;
            end
            cbfd_pkg::ADDR_LINE_LOW: begin
                rdata_next = {2'h0, txd_fault_reg, line_reg.canl_fault};
            end
            cbfd_pkg::ADDR_LPC: begin
                rdata_next = {2'h0, rx_stuck_reg, line_reg.canh_fault};
            end
            default: begin
                rdata_next = 4'h0;
            end
        endcase
    end

    // detector and output registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stuck_cnt_reg <= 2'h0;
            rx_stuck_reg <= 1'b0;
            rxd_fault_reg <= 1'b0;
            dom_cnt_reg <= '0;
            txd_fault_reg <= 1'b0;
            therm_reg <= 1'b0;
            status <= '0;
            spi_rdata <= 4'h0;
            driver_enable <= 1'b0;
            rxd_out <= 1'b1;
            rxd_oe_n <= 1'b1;
            rxd_pulldown_en <= 1'b0;
        end else begin
            stuck_cnt_reg <= stuck_cnt_next;
            rx_stuck_reg <= rx_stuck_next;
            rxd_fault_reg <= rxd_fault_next;
            dom_cnt_reg <= dom_cnt_next;
            txd_fault_reg <= txd_fault_next;
            therm_reg <= therm_next;
            status <= st_next;
            if (spi_read) begin
                spi_rdata <= rdata_next;
            end
            driver_enable <= ~rxd_fault_next & ~txd_fault_next;
            rxd_out <= rxdiff_s;
            rxd_oe_n <= rxd_fault_next;
            rxd_pulldown_en <= rxd_fault_next;
        end
    end
endmodule

// File: cbfd_diag_sva.sv
`timescale 1ns/1ps
// port checker for the diagnostic block
module cbfd_diag_sva #(
    parameter int TXD_TIMEOUT = cbfd_pkg::TXD_TIMEOUT_DEFAULT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic txd_pin,
    input wire logic thermal_event,
    input wire logic spi_valid,
    input wire logic [7:0] spi_byte,
    input wire logic [3:0] spi_rdata,
    input wire logic driver_enable,
    input wire logic rxd_oe_n,
    input wire logic rxd_pulldown_en,
    input wire cbfd_pkg::cbfd_status_t status
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    int low_cnt;
    wire [2:0] adr = spi_byte[7:5];
    wire rd = spi_valid && !spi_byte[4];
    wire clr_cmd = spi_valid && spi_byte[4] && spi_byte[0] &&
        adr == cbfd_pkg::ADDR_CAN;
    // cycles that transmit data has been held dominant
    always_ff @(posedge clock) begin
        if (!rst_n || txd_pin) low_cnt <= 0;
        else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
    end
    sequence therm_seen;
        ##[1:6] status.thermal_overcurrent_flag;
    endsequence
    uf_needs_f_a:
        assert property (status.bus_fault_unidentified |-> status.bus_fault)
        else $error("unidentified flag without bus fault");
    txd_flag_off_a:
        assert property ($rose(status.txd_dominant_fault) |-> !driver_enable)
        else $error("timeout flag with driver on");
    dom_timeout_a:
        assert property (low_cnt > TXD_TIMEOUT + 6 |-> !driver_enable)
        else $error("driver still on after dominant timeout");
    no_self_on_a:
        assert property (!driver_enable && !clr_cmd && !$past(clr_cmd) &&
            (status.txd_dominant_fault || rxd_pulldown_en) |=> !driver_enable)
        else $error("driver came back without command");
    pd_release_a:
        assert property (rxd_pulldown_en |-> rxd_oe_n)
        else $error("pull-down on while rxd driven");
    stuck_off_a:
        assert property ($rose(rxd_pulldown_en) |-> ##[0:2]
            (!driver_enable && status.rx_stuck_recessive_flag))
        else $error("stuck fault without driver off and flag");
    therm_flag_a:
        assert property ($rose(thermal_event) |-> therm_seen)
        else $error("thermal flag not set");
    unmapped_rd_a:
        assert property (rd && adr != cbfd_pkg::ADDR_CAN &&
            adr != cbfd_pkg::ADDR_LINE_LOW && adr != cbfd_pkg::ADDR_LPC
            |=> spi_rdata == 4'h0)
        else $error("unmapped read not zero");
    line_rd_a:
        assert property (rd && adr == cbfd_pkg::ADDR_LINE_LOW |=>
            spi_rdata[0] == status.canl_fault &&
            spi_rdata[1] == status.txd_dominant_fault)
        else $error("line fault read wrong");
endmodule

bind cbfd_diag cbfd_diag_sva #(.TXD_TIMEOUT(TXD_TIMEOUT)) chk_u (
    .clock(clock), .rst_n(rst_n), .txd_pin(txd_pin),
    .thermal_event(thermal_event), .spi_valid(spi_valid),
    .spi_byte(spi_byte), .spi_rdata(spi_rdata),
    .driver_enable(driver_enable), .rxd_oe_n(rxd_oe_n),
    .rxd_pulldown_en(rxd_pulldown_en), .status(status)
);

// File: cbfd_host_model.sv
`timescale 1ns/1ps
// controller side: transmit pin and spi byte master
module cbfd_host_model (
    input wire logic clock,
    output logic txd_pin,
    output logic spi_valid,
    output logic [7:0] spi_byte
);
    initial begin
        txd_pin = 1'b1;
        spi_valid = 1'b0;
        spi_byte = 8'h00;
    end
    // one byte held over exactly one taken edge
    task automatic xfer(input logic [2:0] a, input logic w,
                        input logic [3:0] d);
        @(posedge clock);
        #1;
        spi_byte = {a, w, d};
        spi_valid = 1'b1;
        @(posedge clock);
        #1;
        spi_valid = 1'b0;
        spi_byte = ~spi_byte; // no stale byte left behind
    endtask
    // the host alone decides when the drivers return
    task automatic reenable();
        xfer(cbfd_pkg::ADDR_CAN, 1'b1, 4'h1);
    endtask
    task automatic hold_txd(input logic v);
        @(posedge clock);
        #1;
        txd_pin = v;
    endtask
endmodule

// File: cbfd_pkg.sv
package cbfd_pkg;
    // consecutive recessive-dominant cycles needed to identify a fault
    localparam logic [2:0] IDENT_CYCLES = 3'h5;
    // consecutive bad receive samples needed to call it stuck
    localparam logic [1:0] STUCK_SAMPLES = 2'h3;
    // dominant timeout in device clock cycles (20 MHz clock)
    localparam int TXD_TIMEOUT_DEFAULT = 20000;
    localparam int TXD_CNT_W = 24;

    // comparator snapshot of one bus-line fault signature
    typedef struct packed {
        logic canl_fault;
        logic canh_fault;
    } cbfd_line_t;

    // status bits visible to the register decoder
    typedef struct packed {
        logic bus_fault;               // can register d2
        logic bus_fault_unidentified;  // can register d1
        logic thermal_overcurrent_flag;
        logic canl_fault;              // line_fault_regs_low
        logic txd_dominant_fault;      // line_fault_regs_low
        logic canh_fault;              // low_power_control_reg
        logic rx_stuck_recessive_flag; // low_power_control_reg
    } cbfd_status_t;

    // spi byte layout: 3 address bits, r/w, 4 data bits
    localparam int SPI_ADDR_MSB = 7;
    localparam int SPI_ADDR_LSB = 5;
    localparam int SPI_RW_BIT = 4;
    localparam int SPI_DATA_MSB = 3;
    localparam int SPI_DATA_LSB = 0;
    localparam logic [2:0] ADDR_CAN = 3'h2;
    localparam logic [2:0] ADDR_LINE_LOW = 3'h4;
    localparam logic [2:0] ADDR_LPC = 3'h5;
    localparam int CAN_BIT_CLR = 0;
    localparam int CAN_BIT_UF = 1;
    localparam int CAN_BIT_F = 2;
    localparam int CAN_BIT_THERM = 3;
endpackage

// File: cbfd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for a group of pin inputs
module cbfd_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule
